// ==== inc/ibf_params.svh ====
/*
 Constants of the two-wire bus framing block: offsets, fields, resets, timing.
 Assumes a 200 MHz module clock and 32-bit APB with 12-bit addresses.
*/
`ifndef IBF_PARAMS_SVH
`define IBF_PARAMS_SVH
`define IBF_CLK_NS 5
`define IBF_SCL_HALF_NS 1250
`define IBF_SCL_HALF_CYC (`IBF_SCL_HALF_NS / `IBF_CLK_NS)
`define IBF_IDLE_BASE_CYC 8
`define IBF_HOLD_UNIT_CYC 2
`define IBF_OFS_CTRL 12'h000
`define IBF_OFS_CMD 12'h004
`define IBF_OFS_ADR 12'h008
`define IBF_OFS_TXB 12'h00C
`define IBF_OFS_RXB 12'h010
`define IBF_OFS_STAT 12'h014
`define IBF_CTRL_HOST 0
`define IBF_CTRL_CLIENT 1
`define IBF_CTRL_BYPASS 2
`define IBF_CTRL_ACKDT 3
`define IBF_CTRL_IDLE_LSB 4
`define IBF_CTRL_HOLD_LSB 6
`define IBF_CMD_START 0
`define IBF_CMD_STOP 1
`define IBF_CMD_NEXT 2
`define IBF_STAT_COLL 1
`define IBF_STAT_SSEEN 2
`define IBF_STAT_PSEEN 3
`define IBF_CTRL_RST 8'h00
`define IBF_ADR_RST 15'h0000
`endif

// ==== inc/ibf_pkg.sv ====
/*
 Types of the two-wire bus framing block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ibf_pkg;
    typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_WAIT, H_STOP} ibf_host_st_t;
    typedef enum logic [2:0] {C_IDLE, C_BITS, C_ACK, C_MACK, C_SKIP} ibf_cli_st_t;
endpackage

// ==== inc/ibf_if.sv ====
/*
 Open-drain two-wire bus joining the device end and the far end.
 Assumes each end drives only output values and enables; pull-ups are modelled here.
*/
`timescale 1ns/1ps
interface ibf_if;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic far_scl_o;
    logic far_scl_oe;
    logic far_sda_o;
    logic far_sda_oe;
    logic scl;
    logic sda;
    // Wired-AND with pull-up: a line is low only while somebody pulls it
    assign scl = ~((dev_scl_oe & ~dev_scl_o) | (far_scl_oe & ~far_scl_o));
    assign sda = ~((dev_sda_oe & ~dev_sda_o) | (far_sda_oe & ~far_sda_o));
    modport dev (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
    modport far (output far_scl_o, far_scl_oe, far_sda_o, far_sda_oe, input scl, sda);
endinterface

// ==== verilog/ibf_dev.sv ====
/*
 Device end: host and client framing engine with bus-idle detector, APB registers.
 Assumes bus lines arrive asynchronously and software drives the APB slave.
*/
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "ibf_params.svh"
module ibf_dev #(
    parameter int HALF = `IBF_SCL_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    ibf_if.dev bus
);
    logic scl_m, sda_m, scl_s, sda_s, scl_p, sda_p;
    logic pready_q, pslverr_q, scl_oe_q, sda_oe_q, lo_q;
    logic [31:0] prdata_q;
    logic [7:0] ctrl_q, txb_q, rxb_q, sh_q, c_sh_q;
    logic [14:0] adr_q;
    logic tx_full_q, rx_full_q, go_q, stop_q, next_q, coll_q, sseen_q, pseen_q, ack_q, idle_q;
    logic [15:0] cnt_q, icnt_q;
    logic [3:0] bit_q, c_bit_q;
    logic h_scl_q, h_sda_q, rd_q, first_q, c_scl_q, c_sda_q, c_data_q, c_rd_q;
    ibf_pkg::ibf_host_st_t h_st;
    ibf_pkg::ibf_cli_st_t c_st;

    // Two-stage synchronisers, then edge and condition detection
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3F;
        end else begin
            {scl_m, scl_s, scl_p} <= {bus.scl, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {bus.sda, sda_m, sda_s};
        end
    end
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s;

    wire host_en = ctrl_q[`IBF_CTRL_HOST];
    wire bypass = ctrl_q[`IBF_CTRL_BYPASS];
    wire ack_dt = ctrl_q[`IBF_CTRL_ACKDT];
    wire [15:0] half_c = 16'(HALF);
    wire [15:0] hold_c = 16'((32'(ctrl_q[7:6]) + 32'd1) * `IBF_HOLD_UNIT_CYC);
    wire [15:0] idle_lim = 16'(`IBF_IDLE_BASE_CYC << ctrl_q[5:4]);

    // APB slave: no wait states, error on unmapped offsets
    wire acc = psel_i & penable_i & pready_q;
    wire wr = acc & pwrite_i;
    wire hit = paddr_i inside {`IBF_OFS_CTRL, `IBF_OFS_CMD, `IBF_OFS_ADR,
                               `IBF_OFS_TXB, `IBF_OFS_RXB, `IBF_OFS_STAT};
    wire wr_cmd = wr && paddr_i == `IBF_OFS_CMD;
    wire wr_txb = wr && paddr_i == `IBF_OFS_TXB;
    // Start requests count only while the host is idle; later writes carry data
    wire go_req = h_st == ibf_pkg::H_IDLE &&
                  (bypass ? wr_cmd && pwdata_i[`IBF_CMD_START] : wr_txb);
    wire wr_stat = wr && paddr_i == `IBF_OFS_STAT;
    wire rd_rxb = acc && !pwrite_i && paddr_i == `IBF_OFS_RXB;
    wire [31:0] stat_w = {23'h0, c_st != ibf_pkg::C_IDLE && c_data_q, h_st != ibf_pkg::H_IDLE,
                          tx_full_q, rx_full_q, ack_q, pseen_q, sseen_q, coll_q, idle_q};
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= psel_i & ~penable_i;
            pslverr_q <= psel_i & ~penable_i & ~hit;
            case (paddr_i)
                `IBF_OFS_CTRL: prdata_q <= {24'h0, ctrl_q};
                `IBF_OFS_ADR: prdata_q <= {17'h0, adr_q};
                `IBF_OFS_TXB: prdata_q <= {24'h0, txb_q};
                `IBF_OFS_RXB: prdata_q <= {24'h0, rxb_q};
                `IBF_OFS_STAT: prdata_q <= stat_w;
                default: prdata_q <= 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `IBF_CTRL_RST;
            adr_q <= `IBF_ADR_RST;
            txb_q <= 8'h00;
        end else if (wr) begin
            if (paddr_i == `IBF_OFS_CTRL) ctrl_q <= pwdata_i[7:0];
            if (paddr_i == `IBF_OFS_ADR) adr_q <= pwdata_i[14:0];
            if (paddr_i == `IBF_OFS_TXB) txb_q <= pwdata_i[7:0];
        end
    end

    // Bus-idle detector
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            icnt_q <= 16'h0;
            idle_q <= 1'b0;
        end else if (start_det || !scl_s || !sda_s) begin
            icnt_q <= 16'h0;
            idle_q <= 1'b0;
        end else if (icnt_q >= idle_lim) begin
            idle_q <= 1'b1;
        end else begin
            icnt_q <= icnt_q + 16'h1;
        end
    end

    // Host engine
    wire h_samp = h_st == ibf_pkg::H_HIGH && scl_s && cnt_q == half_c;
    wire h_coll = h_samp && !rd_q && !bit_q[3] && !h_sda_q && !sda_s;
    wire h_go = h_st == ibf_pkg::H_IDLE && go_q && idle_q && host_en;
    wire h_wait_tx = h_st == ibf_pkg::H_WAIT && !stop_q && !rd_q && tx_full_q;
    wire h_tx_take = (h_st == ibf_pkg::H_START && cnt_q == 16'h0 && !bypass) || h_wait_tx;
    wire h_rx_st = h_st == ibf_pkg::H_HIGH && scl_s && cnt_q == 16'h0 && bit_q == 4'd7 && rd_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || h_coll) begin
            h_st <= ibf_pkg::H_IDLE;
            cnt_q <= 16'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            h_scl_q <= 1'b0;
            h_sda_q <= 1'b0;
            rd_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            case (h_st)
                ibf_pkg::H_IDLE: if (h_go) begin
                    h_sda_q <= 1'b1;
                    cnt_q <= half_c;
                    h_st <= ibf_pkg::H_START;
                end
                ibf_pkg::H_START: if (cnt_q != 16'h0) begin
                    cnt_q <= cnt_q - 16'h1;
                end else begin
                    h_scl_q <= 1'b1;
                    cnt_q <= half_c;
                    bit_q <= 4'h0;
                    sh_q <= bypass ? adr_q[7:0] : txb_q;
                    first_q <= 1'b1;
                    rd_q <= 1'b0;
                    h_st <= ibf_pkg::H_LOW;
                end
                ibf_pkg::H_LOW: begin
                    if (cnt_q == half_c - hold_c) begin
                        // Bit 8 released when sending; when receiving, ack unless ack_dt is set, else released
                        h_sda_q <= bit_q[3] ? (rd_q & ~ack_dt) : (~rd_q & ~sh_q[7]);
                    end
                    if (cnt_q != 16'h0) begin
                        cnt_q <= cnt_q - 16'h1;
                    end else if (!(rd_q && bit_q[3] && rx_full_q)) begin
                        h_scl_q <= 1'b0;
                        cnt_q <= half_c;
                        h_st <= ibf_pkg::H_HIGH;
                    end
                end
                ibf_pkg::H_HIGH: if (scl_s) begin
                    if (h_samp && !bit_q[3]) sh_q <= {sh_q[6:0], sda_s};
                    if (cnt_q != 16'h0) begin
                        cnt_q <= cnt_q - 16'h1;
                    end else begin
                        h_scl_q <= 1'b1;
                        cnt_q <= half_c;
                        if (bit_q[3]) begin
                            first_q <= 1'b0;
                            if (first_q) rd_q <= sh_q[0];
                            h_st <= ibf_pkg::H_WAIT;
                        end else begin
                            bit_q <= bit_q + 4'h1;
                            h_st <= ibf_pkg::H_LOW;
                        end
                    end
                end
                ibf_pkg::H_WAIT: if (stop_q) begin
                    h_sda_q <= 1'b1;
                    cnt_q <= half_c;
                    bit_q <= 4'h0;
                    h_st <= ibf_pkg::H_STOP;
                end else if (rd_q ? next_q : tx_full_q) begin
                    sh_q <= txb_q;
                    bit_q <= 4'h0;
                    cnt_q <= half_c;
                    h_st <= ibf_pkg::H_LOW;
                end
                ibf_pkg::H_STOP: if (bit_q[0] && !scl_s) begin
                    cnt_q <= half_c;
                end else if (cnt_q != 16'h0) begin
                    cnt_q <= cnt_q - 16'h1;
                end else if (!bit_q[0]) begin
                    h_scl_q <= 1'b0;
                    bit_q <= 4'h1;
                    cnt_q <= half_c;
                end else begin
                    h_sda_q <= 1'b0;
                    h_st <= ibf_pkg::H_IDLE;
                end
                default: h_st <= ibf_pkg::H_IDLE;
            endcase
        end
    end

    // Client engine, active only while own host is idle
    wire cli_on = ctrl_q[`IBF_CTRL_CLIENT] && h_st == ibf_pkg::H_IDLE;
    wire c_store = c_st == ibf_pkg::C_ACK && c_scl_q && c_data_q && !rx_full_q;
    wire c_tx_take = scl_fall && ((c_st == ibf_pkg::C_ACK && !c_scl_q && c_rd_q) ||
                                  c_st == ibf_pkg::C_MACK);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !cli_on || stop_det) begin
            c_st <= ibf_pkg::C_IDLE;
            c_scl_q <= 1'b0;
            c_sda_q <= 1'b0;
            c_bit_q <= 4'h0;
            c_sh_q <= 8'h00;
            c_data_q <= 1'b0;
            c_rd_q <= 1'b0;
        end else if (start_det) begin
            c_st <= ibf_pkg::C_BITS;
            c_scl_q <= 1'b0;
            c_sda_q <= 1'b0;
            c_bit_q <= 4'h0;
            c_data_q <= 1'b0;
            c_rd_q <= 1'b0;
        end else begin
            case (c_st)
                ibf_pkg::C_BITS: begin
                    if (scl_rise) begin
                        c_sh_q <= {c_sh_q[6:0], sda_s};
                        c_bit_q <= c_bit_q + 4'h1;
                    end
                    if (scl_fall && c_bit_q == 4'd8) begin
                        c_sda_q <= 1'b0;
                        if (c_rd_q) begin
                            c_st <= ibf_pkg::C_MACK;
                        end else if (c_data_q || c_sh_q[7:1] == adr_q[14:8]) begin
                            c_scl_q <= 1'b1;
                            c_rd_q <= ~c_data_q & c_sh_q[0];
                            c_st <= ibf_pkg::C_ACK;
                        end else begin
                            c_st <= ibf_pkg::C_SKIP;
                        end
                    end else if (scl_fall && c_rd_q) begin
                        c_sda_q <= ~c_sh_q[7];
                    end
                end
                ibf_pkg::C_ACK: if (c_scl_q) begin
                    if (!(c_data_q && rx_full_q)) begin
                        c_scl_q <= 1'b0;
                        c_sda_q <= c_data_q ? ~ack_dt : 1'b1;
                    end
                end else if (scl_fall) begin
                    c_data_q <= 1'b1;
                    c_bit_q <= 4'h0;
                    c_sh_q <= txb_q;
                    c_sda_q <= c_rd_q & ~txb_q[7];
                    c_st <= ibf_pkg::C_BITS;
                end
                ibf_pkg::C_MACK: if (scl_rise && sda_s) begin
                    c_st <= ibf_pkg::C_SKIP;
                end else if (scl_fall) begin
                    c_sh_q <= txb_q;
                    c_sda_q <= ~txb_q[7];
                    c_bit_q <= 4'h0;
                    c_st <= ibf_pkg::C_BITS;
                end
                ibf_pkg::C_SKIP: c_st <= ibf_pkg::C_SKIP;
                default: c_st <= ibf_pkg::C_IDLE;
            endcase
        end
    end

    // Sticky flags and buffers; a hardware set wins over a clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {tx_full_q, rx_full_q, go_q, stop_q, next_q, coll_q, sseen_q, pseen_q} <= 8'h00;
            ack_q <= 1'b0;
            rxb_q <= 8'h00;
        end else begin
            if (h_tx_take || c_tx_take) tx_full_q <= 1'b0;
            if (wr_txb) tx_full_q <= 1'b1;
            if (rd_rxb) rx_full_q <= 1'b0;
            if (h_rx_st || c_store) begin
                rx_full_q <= 1'b1;
                rxb_q <= h_rx_st ? sh_q : c_sh_q;
            end
            if (h_go) go_q <= 1'b0;
            if (go_req) begin
                go_q <= 1'b1;
            end
            if (h_st == ibf_pkg::H_WAIT && (stop_q || next_q)) {stop_q, next_q} <= 2'b00;
            if (wr_cmd && pwdata_i[`IBF_CMD_STOP]) stop_q <= 1'b1;
            if (wr_cmd && pwdata_i[`IBF_CMD_NEXT]) next_q <= 1'b1;
            if (h_samp && bit_q[3] && !rd_q) ack_q <= sda_s;
            if (wr_stat && pwdata_i[`IBF_STAT_COLL]) coll_q <= 1'b0;
            if (h_coll) coll_q <= 1'b1;
            if (wr_stat && pwdata_i[`IBF_STAT_SSEEN]) sseen_q <= 1'b0;
            if (start_det) sseen_q <= 1'b1;
            if (wr_stat && pwdata_i[`IBF_STAT_PSEEN]) pseen_q <= 1'b0;
            if (stop_det) pseen_q <= 1'b1;
        end
    end

    // Pin drivers: only low is ever driven
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {scl_oe_q, sda_oe_q, lo_q} <= 3'b000;
        end else begin
            scl_oe_q <= h_scl_q | c_scl_q;
            sda_oe_q <= h_sda_q | c_sda_q;
            lo_q <= 1'b0;
        end
    end
    assign bus.dev_scl_o = lo_q;
    assign bus.dev_sda_o = lo_q;
    assign bus.dev_scl_oe = scl_oe_q;
    assign bus.dev_sda_oe = sda_oe_q;
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
endmodule

// ==== verilog/ibf_far.sv ====
/*
 Far end: a plain client on the two-wire bus that answers a given address.
 Assumes a host elsewhere on the bus makes every clock; user side on clk_i.
*/
`timescale 1ns/1ps
module ibf_far (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [6:0] own_addr_i,
    input wire logic [7:0] tx_data_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic sel_o,
    ibf_if.far bus
);
    logic scl_m, sda_m, scl_s, sda_s, scl_p, sda_p;
    logic [7:0] sh_q, rx_q;
    logic [3:0] bit_q;
    logic sda_q, data_q, rd_q, valid_q, lo_q;
    ibf_pkg::ibf_cli_st_t st;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3F;
        end else begin
            {scl_m, scl_s, scl_p} <= {bus.scl, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {bus.sda, sda_m, sda_s};
        end
    end
    wire rise = scl_s & ~scl_p;
    wire fall = ~scl_s & scl_p;
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || stop_det) begin
            st <= ibf_pkg::C_IDLE;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            bit_q <= 4'h0;
            {sda_q, data_q, rd_q, valid_q} <= 4'h0;
        end else if (start_det) begin
            st <= ibf_pkg::C_BITS;
            bit_q <= 4'h0;
            {sda_q, data_q, rd_q, valid_q} <= 4'h0;
        end else begin
            valid_q <= 1'b0;
            case (st)
                ibf_pkg::C_BITS: begin
                    if (rise) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (fall && bit_q == 4'd8) begin
                        if (rd_q) begin
                            sda_q <= 1'b0;
                            st <= ibf_pkg::C_MACK;
                        end else if (data_q || sh_q[7:1] == own_addr_i) begin
                            sda_q <= 1'b1;
                            rd_q <= ~data_q & sh_q[0];
                            if (data_q) begin
                                rx_q <= sh_q;
                                valid_q <= 1'b1;
                            end
                            st <= ibf_pkg::C_ACK;
                        end else begin
                            st <= ibf_pkg::C_SKIP;
                        end
                    end else if (fall && rd_q) begin
                        sda_q <= ~sh_q[7];
                    end
                end
                ibf_pkg::C_ACK: if (fall) begin
                    data_q <= 1'b1;
                    bit_q <= 4'h0;
                    sh_q <= tx_data_i;
                    sda_q <= rd_q & ~tx_data_i[7];
                    st <= ibf_pkg::C_BITS;
                end
                ibf_pkg::C_MACK: if (rise && sda_s) begin
                    st <= ibf_pkg::C_SKIP;
                end else if (fall) begin
                    sh_q <= tx_data_i;
                    sda_q <= ~tx_data_i[7];
                    bit_q <= 4'h0;
                    st <= ibf_pkg::C_BITS;
                end
                ibf_pkg::C_SKIP: st <= ibf_pkg::C_SKIP;
                default: st <= ibf_pkg::C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) lo_q <= 1'b0;
        else lo_q <= 1'b0;
    end
    assign bus.far_scl_o = lo_q;
    assign bus.far_scl_oe = lo_q;
    assign bus.far_sda_o = lo_q;
    assign bus.far_sda_oe = sda_q;
    assign rx_data_o = rx_q;
    assign rx_valid_o = valid_q;
    assign sel_o = data_q;
endmodule

// ==== sim/ibf_sva.sv ====
/*
 Checker for the two-wire bus joining the device end and the far client.
 Assumes the interface signals arrive as plain inputs on the module clock.
*/
`timescale 1ns/1ps
module ibf_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dev_scl_o,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic far_scl_o,
    input wire logic far_scl_oe,
    input wire logic far_sda_o,
    input wire logic far_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [7:0] hi_q;
    // Cycles both lines have stayed high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !(scl && sda)) begin
            hi_q <= 8'h00;
        end else if (hi_q != 8'hFF) begin
            hi_q <= hi_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_dev_low_only:
        assert property (!dev_scl_o && !dev_sda_o) else $error("device drives a line high");
    a_far_low_only:
        assert property (!far_scl_o && !far_sda_o) else $error("far end drives a line high");
    a_far_clk_input:
        assert property (!far_scl_oe) else $error("client pulls the clock");
    a_start_order:
        assert property ($rose(dev_sda_oe) && scl |=> scl [*8]) else $error("start order");
    a_idle_gap:
        assert property ($rose(dev_sda_oe) && scl |-> hi_q >= 8'h08) else $error("start early");
    a_far_data_low:
        assert property ($changed(far_sda_oe) |-> !scl) else $error("far data moved high");
    a_far_bit_hold:
        assert property ($rose(far_sda_oe) |=> far_sda_oe [*8]) else $error("far bit short");
    a_hold_delay:
        assert property ($fell(scl) |=> $stable(dev_sda_oe)) else $error("no hold delay");
    a_host_low:
        assert property ($rose(dev_scl_oe) |=> dev_scl_oe [*8]) else $error("clock low short");
    c_start: cover property ($rose(dev_sda_oe) && scl);
    c_stop: cover property ($fell(dev_sda_oe) && scl);
    c_far_ack: cover property ($rose(far_sda_oe));
endmodule

// ==== sim/ibf_bench.sv ====
/*
 Bench: APB host traffic from the device end to the far client.
 Assumes both ends on one 200 MHz clock and the interface pull-ups.
*/
`timescale 1ns/1ps
`include "ibf_params.svh"
module ibf_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready_o, pslverr_o, e, sel, rx_valid;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata_o, r;
    logic [7:0] rx_data;
    int err_count = 0, n_tests = 0, n_rx = 0;
    ibf_if bus_if();
    always #2.5 clk_i = ~clk_i;
    // Counts data bytes handed over by the far client
    always @(posedge clk_i) begin
        if (rx_valid === 1'b1) n_rx <= n_rx + 1;
    end
    ibf_dev #(.HALF(20)) ibf_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .bus(bus_if));
    ibf_far ibf_far_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .own_addr_i(7'h2A),
        .tx_data_i(8'h5A), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .sel_o(sel),
        .bus(bus_if));
    ibf_sva ibf_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_scl_o(bus_if.dev_scl_o),
        .dev_scl_oe(bus_if.dev_scl_oe), .dev_sda_o(bus_if.dev_sda_o),
        .dev_sda_oe(bus_if.dev_sda_oe), .far_scl_o(bus_if.far_scl_o),
        .far_scl_oe(bus_if.far_scl_oe), .far_sda_o(bus_if.far_sda_o),
        .far_sda_oe(bus_if.far_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
    task automatic stop_test;
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_stat(input int b, input logic v);
        int n = 0;
        do begin
            apb(1'b0, `IBF_OFS_STAT, 32'h0000_0000);
            n++;
        end while (r[b] !== v && n < 500);
        chk(r[b], v);
    endtask
    // Waits for the clock to rise, then for the host's long low hold
    task automatic wait_low;
        int n = 0;
        int lo = 0;
        logic hi = 1'b0;
        while (lo < 80 && n < 5000) begin
            @(posedge clk_i);
            n++;
            hi = hi | (bus_if.scl === 1'b1);
            lo = (hi && bus_if.scl === 1'b0) ? lo + 1 : 0;
        end
        chk(lo, 80);
    endtask
    task automatic stop;
        apb(1'b1, `IBF_OFS_STAT, 32'h0000_0008);
        apb(1'b1, `IBF_OFS_CMD, 32'h0000_0002);
        wait_stat(0, 1'b1);
        chk(r[3], 1'b1);
        chk(sel, 1'b0);
    endtask
    task automatic t_regs;
        apb(1'b0, `IBF_OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        chk(e, 1'b1);
        chk(r, 32'h0000_0000);
        wait_stat(0, 1'b1);
    endtask
    task automatic t_write;
        apb(1'b1, `IBF_OFS_CTRL, 32'h0000_0051);
        apb(1'b1, `IBF_OFS_TXB, 32'h0000_0054);
        wait_low;
        apb(1'b0, `IBF_OFS_STAT, 32'h0000_0000);
        chk(r[4] | r[0], 1'b0);
        chk(r[2] & sel, 1'b1);
        chk(r[7] & ~r[6], 1'b1);
        apb(1'b1, `IBF_OFS_TXB, 32'h0000_00A5);
        wait_low;
        chk(rx_data, 8'hA5);
        apb(1'b1, `IBF_OFS_TXB, 32'h0000_003C);
        wait_low;
        chk(rx_data, 8'h3C);
        chk(n_rx, 32'h0000_0002);
        stop;
    endtask
    task automatic t_nack;
        apb(1'b1, `IBF_OFS_CTRL, 32'h0000_0011);
        apb(1'b1, `IBF_OFS_TXB, 32'h0000_00A0);
        wait_low;
        apb(1'b0, `IBF_OFS_STAT, 32'h0000_0000);
        chk(r[4], 1'b1);
        chk(sel, 1'b0);
        stop;
    endtask
    task automatic t_read;
        apb(1'b1, `IBF_OFS_CTRL, 32'h0000_0059);
        apb(1'b1, `IBF_OFS_TXB, 32'h0000_0055);
        wait_low;
        apb(1'b1, `IBF_OFS_CMD, 32'h0000_0004);
        wait_stat(5, 1'b1);
        apb(1'b0, `IBF_OFS_RXB, 32'h0000_0000);
        chk(r, 32'h0000_005A);
        wait_low;
        stop;
    endtask
    task automatic t_bypass;
        apb(1'b1, `IBF_OFS_CTRL, 32'h0000_0015);
        apb(1'b1, `IBF_OFS_ADR, 32'h0000_0054);
        apb(1'b1, `IBF_OFS_CMD, 32'h0000_0001);
        wait_low;
        chk(sel, 1'b1);
        stop;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_write;
        t_nack;
        t_read;
        t_bypass;
        stop_test;
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        err_count++;
        stop_test;
    end
endmodule
